// ===== design/isac_top.sv
// Interval scan acquisition controller: sequencing, timers, register slave.
// Assumes synchronous inputs and a classic Wishbone master on the bus.
// Summary of operation
// - Scan bit clear: pointer never moves
// - Interval bit set: every pass is timed
// - Interval count starts at pass's first conversion
// - Next pass waits for interval terminal count
// - Start at entry zero, step after conversion
// - Flagged entry marks the end of sequence
// - Interval bit set: pause after each flagged entry for interval
// - End of list: back to zero, after the wait if interval bit set
// - Divide bit: step on counter1 low pulse
// - Divide bit clear: step every conversion
// - Clear, write entries in order, then load
// - Sample timer pulses low every N ticks
// - Sample counter tallies conversions, stops timer
// - Width bit clear: inner counter alone ends
// - Stop acquisition when sample count hits zero; width bit set: at inner terminal count with outer stage at zero
// - No conversion pulses before the trigger
// - Converter clear empties the result buffer
// - Start by register write or trigger pulse
`default_nettype none
module isac_top
    import isac_pkg::*;
#(
    parameter int SEQ_DEPTH = 16,
    parameter int PTR_W     = $clog2(SEQ_DEPTH)
) (
    input  wire logic        clk_i,        // 25 MHz system clock
    input  wire logic        rst_i,        // Synchronous reset, high
    input  wire logic        cyc_i,        // Wishbone cycle
    input  wire logic        stb_i,        // Wishbone strobe
    input  wire logic        we_i,         // Wishbone write
    input  wire logic [7:0]  adr_i,        // Wishbone byte address
    input  wire logic [3:0]  sel_i,        // Wishbone byte selects
    input  wire logic [31:0] dat_i,        // Wishbone write data
    output logic      [31:0] dat_o,        // Wishbone read data
    output logic             ack_o,        // Wishbone acknowledge
    input  wire logic        timebase_i,   // Selected timebase, rising edge
    input  wire logic        counter1_output_i,   // Divider output
    input  wire logic        external_trigger_input_n_i, // Trigger, low
    input  wire logic        upper_count_zero_i,  // Cascade stage at zero
    output logic             conv_n_o,     // Conversion pulse, low
    output logic [ENTRY_W-2:0] chan_gain_o, // Current channel and gain
    output logic             eos_o,        // Current entry ends a pass
    output logic             acq_active_o, // Acquisition running
    output logic             fifo_clear_o  // Empty result buffer pulse
);
    import isac_pkg::*;

    isac_state_e          state_q;
    logic [CMD_W-1:0]     cmd1_q;
    logic [CNT_W-1:0]     smp_intvl_q, smp_count_q, scn_intvl_q;
    logic [PTR_W-1:0]     wptr_q, rptr_q;
    logic [PTR_W:0]       nent_q;
    logic [ENTRY_W-1:0]   entry;
    logic                 tb_prev_q, c1_prev_q, trig_prev_q;
    logic                 tick, c1_fall, trig_fall;
    logic                 req, wr_fire, wr16;
    logic                 wr_clr, wr_ent, wr_load, wr_start, wr_cclr;
    logic                 trigger, conv_fire, smp_tc, scn_tc, step;
    logic                 pass_first_q, scn_busy_q, scn_done_q;
    logic                 end_acq, last_ent, at_eos;
    logic [CNT_W:0]       smp_left;
    logic [31:0]          rd_mux;

    // Next pointer, wrapping at the end of the written list
    function automatic logic [PTR_W-1:0] next_ptr(
        input logic [PTR_W-1:0] p,
        input logic [PTR_W:0]   n
    );
        logic [PTR_W:0] p1;
        p1 = {1'b0, p} + 1'b1;
        next_ptr = (p1 >= n) ? '0 : p1[PTR_W-1:0];
    endfunction

    // Bus decode; a write takes effect at the edge where ack is seen high
    assign req     = cyc_i && stb_i;
    assign wr_fire = req && we_i && ack_o;
    assign wr16    = wr_fire && (sel_i[1:0] == 2'b11);
    assign wr_clr   = wr16 && adr_i == REG_SEQ_CLEAR;
    assign wr_ent   = wr16 && adr_i == REG_SEQ_ENTRY;
    assign wr_load  = wr16 && adr_i == REG_SEQ_LOAD;
    assign wr_start = wr16 && adr_i == REG_ACQ_START;
    assign wr_cclr  = wr16 && adr_i == REG_CONV_CLR;

    // Input edge detection
    assign tick      = timebase_i && !tb_prev_q;
    assign c1_fall   = !counter1_output_i && c1_prev_q;
    assign trig_fall = !external_trigger_input_n_i && trig_prev_q;
    assign trigger   = (wr_start || trig_fall) && cmd1_q[CMD_ACQ_EN];

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tb_prev_q   <= 1'b0;
            c1_prev_q   <= 1'b1;
            trig_prev_q <= 1'b1;
        end else begin
            tb_prev_q   <= timebase_i;
            c1_prev_q   <= counter1_output_i;
            trig_prev_q <= external_trigger_input_n_i;
        end
    end

    // Single-wait-state acknowledge, dropped the cycle after it is given
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
        end else begin
            ack_o <= req && !ack_o;
        end
    end

    // Software-written configuration
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cmd1_q      <= CMD1_RST;
            smp_intvl_q <= INTVL_RST;
            smp_count_q <= COUNT_RST;
            scn_intvl_q <= INTVL_RST;
        end else if (wr16) begin
            unique case (adr_i)
                REG_CMD1:      cmd1_q      <= dat_i[CMD_W-1:0];
                REG_SMP_INTVL: smp_intvl_q <= dat_i[CNT_W-1:0];
                REG_SMP_COUNT: smp_count_q <= dat_i[CNT_W-1:0];
                REG_SCN_INTVL: scn_intvl_q <= dat_i[CNT_W-1:0];
                default: ;
            endcase
        end
    end

    // Read data registered on the request edge, valid with ack
    always_comb begin
        rd_mux = 32'h0000_0000;
        unique case (adr_i)
            REG_CMD1:      rd_mux[CMD_W-1:0] = cmd1_q;
            REG_SMP_INTVL: rd_mux[CNT_W-1:0] = smp_intvl_q;
            REG_SMP_COUNT: rd_mux[CNT_W-1:0] = smp_count_q;
            REG_SCN_INTVL: rd_mux[CNT_W-1:0] = scn_intvl_q;
            REG_STATUS: begin
                // Pointer from bit 8 up, pass flags in the low bits
                rd_mux[8 +: PTR_W] = rptr_q;
                rd_mux[2]          = scn_done_q;
                rd_mux[1]          = state_q == ST_HOLD;
                rd_mux[0]          = acq_active_o;
            end
            REG_SMP_LEFT:  rd_mux[CNT_W:0] = smp_left;
            default:       rd_mux = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dat_o <= 32'h0000_0000;
        end else if (req && !ack_o) begin
            dat_o <= rd_mux;
        end
    end

    // Sequence store: clear, then entries land at consecutive locations
    always_ff @(posedge clk_i) begin
        if (rst_i || wr_clr) begin
            wptr_q <= '0;
            nent_q <= '0;
        end else if (wr_ent && nent_q < (PTR_W+1)'(SEQ_DEPTH)) begin
            wptr_q <= wptr_q + 1'b1;
            nent_q <= nent_q + 1'b1;
        end
    end

    isac_seq_mem #(
        .WIDTH (ENTRY_W),
        .DEPTH (SEQ_DEPTH)
    ) u_mem (
        .clk_i   (clk_i),
        .we_i    (wr_ent && nent_q < (PTR_W+1)'(SEQ_DEPTH)),
        .waddr_i (wptr_q),
        .wdata_i (dat_i[ENTRY_W-1:0]),
        .raddr_i (rptr_q),
        .rdata_o (entry)
    );

    assign chan_gain_o = entry[ENTRY_W-2:0];
    assign eos_o       = entry[EOS_BIT];

    // Sample-interval timer runs only while running, frozen in hold
    isac_down_counter #(.W(CNT_W)) u_smp_intvl (
        .clk_i    (clk_i),
        .rst_i    (rst_i),
        .load_i   (trigger && state_q == ST_IDLE),
        .dec_i    (tick && state_q == ST_RUN),
        .reload_i (1'b1),
        .value_i  (smp_intvl_q),
        .count_o  (),
        .tc_o     (conv_fire)
    );

    // Sample counter tallies conversions from the interval timer
    isac_down_counter #(.W(CNT_W)) u_smp_count (
        .clk_i    (clk_i),
        .rst_i    (rst_i),
        .load_i   (trigger && state_q == ST_IDLE),
        .dec_i    (conv_fire),
        .reload_i (cmd1_q[CMD_CNT_WID]),
        .value_i  (smp_count_q),
        .count_o  (smp_left),
        .tc_o     (smp_tc)
    );

    // Scan-interval counter, started by a pass's first conversion
    isac_down_counter #(.W(CNT_W)) u_scn_intvl (
        .clk_i    (clk_i),
        .rst_i    (rst_i),
        .load_i   (conv_fire && pass_first_q),
        .dec_i    (tick && scn_busy_q),
        .reload_i (1'b0),
        .value_i  (scn_intvl_q),
        .count_o  (),
        .tc_o     (scn_tc)
    );

    // Single-counter mode ends on the inner terminal count alone
    assign end_acq = smp_tc && (!cmd1_q[CMD_CNT_WID]
                                || upper_count_zero_i);

    // Pass timing flags; terminal count wins over a fresh load's clear
    always_ff @(posedge clk_i) begin
        if (rst_i || (trigger && state_q == ST_IDLE)) begin
            pass_first_q <= 1'b1;
            scn_busy_q   <= 1'b0;
            scn_done_q   <= 1'b0;
        end else begin
            if (state_q == ST_HOLD && scn_done_q) begin
                pass_first_q <= 1'b1;
            end else if (conv_fire) begin
                pass_first_q <= 1'b0;
            end
            if (scn_tc) begin
                scn_busy_q <= 1'b0;
                scn_done_q <= 1'b1;
            end else if (conv_fire && pass_first_q) begin
                scn_busy_q <= cmd1_q[CMD_SCN_INT];
                scn_done_q <= 1'b0;
            end else if (state_q == ST_HOLD && scn_done_q) begin
                scn_done_q <= 1'b0;
            end
        end
    end

    // Stepping source: divider pulse or every conversion, scan bit only
    assign step     = cmd1_q[CMD_SCAN_EN] && state_q == ST_RUN &&
                      (cmd1_q[CMD_SCAN_DIV] ? c1_fall
                                            : conv_fire);
    assign at_eos   = entry[EOS_BIT];
    assign last_ent = next_ptr(rptr_q, nent_q) == '0;

    // Acquisition state
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_q <= ST_IDLE;
        end else begin
            unique case (state_q)
                ST_IDLE: begin
                    if (trigger) begin
                        state_q <= ST_RUN;
                    end
                end
                ST_RUN: begin
                    if (end_acq || !cmd1_q[CMD_ACQ_EN]) begin
                        state_q <= ST_IDLE;
                    end else if (step && cmd1_q[CMD_SCN_INT]
                                 && (at_eos || last_ent)) begin
                        state_q <= ST_HOLD;
                    end
                end
                ST_HOLD: begin
                    if (!cmd1_q[CMD_ACQ_EN]) begin
                        state_q <= ST_IDLE;
                    end else if (scn_done_q) begin
                        state_q <= ST_RUN;
                    end
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    // Pointer: held during the pause, moved on release
    always_ff @(posedge clk_i) begin
        if (rst_i || wr_load) begin
            rptr_q <= '0;
        end else if (state_q == ST_HOLD && scn_done_q) begin
            rptr_q <= next_ptr(rptr_q, nent_q);
        end else if (step && !(cmd1_q[CMD_SCN_INT]
                               && (at_eos || last_ent))) begin
            rptr_q <= next_ptr(rptr_q, nent_q);
        end
    end

    // Registered outputs
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            conv_n_o     <= 1'b1;
            fifo_clear_o <= 1'b0;
        end else begin
            conv_n_o     <= !conv_fire;
            fifo_clear_o <= wr_cclr;
        end
    end

    assign acq_active_o = state_q != ST_IDLE;

    a_conv_after_trig: assert property (@(posedge clk_i) disable iff (rst_i)
        !conv_n_o |-> $past(state_q) == ST_RUN)
        else $error("conversion outside running state");
    a_conv_pulse_low: assert property (@(posedge clk_i) disable iff (rst_i)
        conv_fire |=> !conv_n_o ##1 conv_n_o)
        else $error("conversion pulse not one low cycle");
    a_stop_at_zero: assert property (@(posedge clk_i) disable iff (rst_i)
        (smp_tc && !cmd1_q[CMD_CNT_WID]) |=> state_q == ST_IDLE)
        else $error("acquisition did not stop at zero");
    a_ptr_no_scan: assert property (@(posedge clk_i) disable iff (rst_i)
        (!cmd1_q[CMD_SCAN_EN] && state_q == ST_RUN && !wr_load)
        |=> rptr_q == $past(rptr_q))
        else $error("pointer moved with scanning off");
    a_step_each_conv: assert property (@(posedge clk_i) disable iff (rst_i)
        (step && !cmd1_q[CMD_SCAN_DIV] && !cmd1_q[CMD_SCN_INT] && !wr_load)
        |=> rptr_q == next_ptr($past(rptr_q), nent_q))
        else $error("pointer did not advance after conversion");
    a_div_waits_c1: assert property (@(posedge clk_i) disable iff (rst_i)
        (cmd1_q[CMD_SCAN_DIV] && !c1_fall && state_q == ST_RUN && !wr_load)
        |=> rptr_q == $past(rptr_q))
        else $error("pointer moved without divider pulse");
    a_pause_at_eos: assert property (@(posedge clk_i) disable iff (rst_i)
        (step && cmd1_q[CMD_SCN_INT] && at_eos && !end_acq
         && cmd1_q[CMD_ACQ_EN]) |=> state_q == ST_HOLD)
        else $error("no pause after flagged entry");
    a_hold_no_conv: assert property (@(posedge clk_i) disable iff (rst_i)
        (state_q == ST_HOLD && !scn_done_q) |=> !conv_fire)
        else $error("conversion during interval pause");
    a_list_wraps: assert property (@(posedge clk_i) disable iff (rst_i)
        (state_q == ST_HOLD && scn_done_q && last_ent && !wr_load
         && cmd1_q[CMD_ACQ_EN]) |=> rptr_q == '0 && state_q == ST_RUN)
        else $error("pointer not returned to zero");
    a_load_zero: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_load |=> rptr_q == '0)
        else $error("load did not select location zero");
    a_trig_starts: assert property (@(posedge clk_i) disable iff (rst_i)
        (trigger && state_q == ST_IDLE) |=> state_q == ST_RUN)
        else $error("trigger did not start acquisition");
endmodule
`default_nettype wire

// ===== common/isac_pkg.sv
// Package for the interval scan acquisition controller.
// Assumes a 32-bit classic Wishbone register bus, 16-bit values in low lanes.
`default_nettype none
package isac_pkg;
    // Register byte offsets
    localparam logic [7:0] REG_CMD1      = 8'h00;
    localparam logic [7:0] REG_SEQ_CLEAR = 8'h04;
    localparam logic [7:0] REG_SEQ_ENTRY = 8'h08;
    localparam logic [7:0] REG_SEQ_LOAD  = 8'h0C;
    localparam logic [7:0] REG_CONV_CLR  = 8'h10;
    localparam logic [7:0] REG_ACQ_START = 8'h14;
    localparam logic [7:0] REG_SMP_INTVL = 8'h18;
    localparam logic [7:0] REG_SMP_COUNT = 8'h1C;
    localparam logic [7:0] REG_SCN_INTVL = 8'h20;
    localparam logic [7:0] REG_STATUS    = 8'h24;
    localparam logic [7:0] REG_SMP_LEFT  = 8'h28;
    // First command register bit positions
    localparam int CMD_ACQ_EN   = 0;
    localparam int CMD_SCAN_EN  = 1;
    localparam int CMD_SCN_INT  = 2;
    localparam int CMD_SCAN_DIV = 3;
    localparam int CMD_CNT_WID  = 4;
    localparam int CMD_W        = 5;
    // Sequence entry layout: end-of-sequence flag in the top bit
    localparam int ENTRY_W      = 16;
    localparam int EOS_BIT      = 15;
    // Reset values
    localparam logic [CMD_W-1:0] CMD1_RST  = 5'h00;
    localparam logic [15:0]      INTVL_RST = 16'h0002;
    localparam logic [15:0]      COUNT_RST = 16'h0002;
    // Counter width; a loaded 0 means 65,536 counts
    localparam int CNT_W = 16;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_RUN  = 2'b01,
        ST_HOLD = 2'b10
    } isac_state_e;
endpackage
`default_nettype wire

// ===== design/isac_seq_mem.sv
// Channel-gain sequence memory, one write port, registered read.
// Assumes write and read addresses are already in range.
`default_nettype none
module isac_seq_mem #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 16,
    parameter int AW    = $clog2(DEPTH)
) (
    input  wire logic             clk_i,   // System clock
    input  wire logic             we_i,    // Write strobe
    input  wire logic [AW-1:0]    waddr_i, // Write location
    input  wire logic [WIDTH-1:0] wdata_i, // Entry to store
    input  wire logic [AW-1:0]    raddr_i, // Read location
    output logic      [WIDTH-1:0] rdata_o  // Registered entry
);
    logic [WIDTH-1:0] mem_q [DEPTH];

    // Storage, no reset: contents are defined by software loading
    always_ff @(posedge clk_i) begin
        if (we_i) begin
            mem_q[waddr_i] <= wdata_i;
        end
    end

    // Read every cycle so the entry follows the pointer one cycle later
    always_ff @(posedge clk_i) begin
        rdata_o <= mem_q[raddr_i];
    end
endmodule
`default_nettype wire

// ===== design/isac_down_counter.sv
// Loadable down counter with terminal-count pulse and optional reload.
// Assumes load and decrement are never requested in the same cycle.
`default_nettype none
module isac_down_counter #(
    parameter int W = 16
) (
    input  wire logic         clk_i,    // System clock
    input  wire logic         rst_i,    // Synchronous reset, high
    input  wire logic         load_i,   // Load value_i
    input  wire logic         dec_i,    // Count one step
    input  wire logic         reload_i, // Reload on terminal count
    input  wire logic [W-1:0] value_i,  // Load value, 0 means 2**W
    output logic      [W:0]   count_o,  // Counts remaining
    output logic              tc_o      // Terminal count pulse
);
    logic [W:0] load_val;

    // Zero encodes the full range of 2**W counts
    assign load_val = (value_i == '0) ? {1'b1, {W{1'b0}}} : {1'b0, value_i};
    assign tc_o     = dec_i && (count_o == {{W{1'b0}}, 1'b1});

    // Count down; stop at zero unless reloading
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            count_o <= '0;
        end else if (load_i) begin
            count_o <= load_val;
        end else if (tc_o) begin
            count_o <= reload_i ? load_val : '0;
        end else if (dec_i && count_o != '0) begin
            count_o <= count_o - 1'b1;
        end
    end
endmodule
`default_nettype wire

// ===== sim/isac_timer_model.sv
// Far-side model: counter/timer outputs and the trigger pin.
// Assumes the bench steers trigger, divider and outer stage by requests.
`default_nettype none
module isac_timer_model (
    input  wire logic clk_i,      // System clock
    input  wire logic rst_i,      // Synchronous reset, high
    input  wire logic trig_i,     // Bench asks for a trigger
    input  wire logic div_i,      // Bench asks for a divider pulse
    input  wire logic upz_i,      // Bench marks the outer stage empty
    output logic      timebase_o, // Selected timebase
    output logic      div_n_o,    // Divider output, low pulse
    output logic      trig_n_o,   // Trigger pin, low
    output logic      upz_o       // Cascade stage at zero
);
    timeunit 1ns;
    timeprecision 1ns;
    // Timebase runs free: a rising edge every two clocks
    always_ff @(posedge clk_i) begin
        timebase_o <= rst_i ? 1'b0 : ~timebase_o;
        div_n_o    <= ~div_i; // Divider pulse only on request
        trig_n_o   <= ~trig_i;
        upz_o      <= upz_i; // Outer stage, steered by bench
    end
endmodule
`default_nettype wire

// ===== sim/isac_top_tb_top.sv
// Self-checking bench for the interval scan acquisition controller.
// Assumes the far-side model supplies timebase, divider and trigger.
`default_nettype none
module isac_top_tb_top
    import isac_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, trig = 0;
    logic [7:0]  adr = 0;
    logic [3:0]  sel = 0;
    logic [31:0] dat = 0, dat_o;
    logic        ack_o, tbase, div_n, trig_n, upz, conv_n, eos, act, fclr;
    logic [14:0] cg;
    logic [14:0] seen[$];
    int          bad_count = 0, n_checks = 0, seed = 27835;
    int          cyc_n = 0, t1, t2, t4;
    int          cur_mode = 0, n_eos = 0;
    logic        div_req = 0, upz_req = 0;
    logic        fc_seen;

    isac_top dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb),
        .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(dat), .dat_o(dat_o),
        .ack_o(ack_o), .timebase_i(tbase), .counter1_output_i(div_n),
        .external_trigger_input_n_i(trig_n), .upper_count_zero_i(upz),
        .conv_n_o(conv_n), .chan_gain_o(cg), .eos_o(eos),
        .acq_active_o(act), .fifo_clear_o(fclr));
    isac_timer_model u_far (.clk_i(clk_i), .rst_i(rst_i), .trig_i(trig),
        .div_i(div_req), .upz_i(upz_req),
        .timebase_o(tbase), .div_n_o(div_n), .trig_n_o(trig_n),
        .upz_o(upz));

    // 25 MHz clock
    initial forever #20 clk_i = ~clk_i;

    // Record each conversion and the entry it used; steer far-side pins
    always @(posedge clk_i) begin
        cyc_n++;
        if (fclr === 1'b1) fc_seen = 1;
        // One divider pulse right after the third conversion
        div_req <= (cur_mode == 2 && conv_n === 1'b0 && seen.size() == 2);
        if (conv_n === 1'b0) begin
            seen.push_back(cg);
            if (eos === 1'b1) n_eos++;
            if (seen.size() == 1) t1 = cyc_n;
            if (seen.size() == 2) t2 = cyc_n;
            if (seen.size() == 4) t4 = cyc_n;
        end
        // Outer stage empties after the first inner round
        upz_req <= (cur_mode == 4 && seen.size() >= 6);
    end

    task chk(input logic ok, input string m);
        n_checks++;
        if (ok !== 1'b1) begin
            bad_count++;
            $display("CHECK FAILED %0t %s", $time, m);
        end
    endtask

    // Classic single Wishbone cycle; waits for ack, watchdog ends a hang
    task wb(input logic w, input logic [7:0] a, input logic [31:0] d,
            output logic [31:0] r);
        @(posedge clk_i);
        cyc <= 1; stb <= 1; we <= w; adr <= a; dat <= d; sel <= 4'hF;
        do @(posedge clk_i); while (ack_o !== 1'b1);
        r = dat_o;
        cyc <= 0; stb <= 0; we <= 0;
    endtask

    // Entry index expected for the k-th conversion of mode m
    function automatic int exp_idx(input int m, input int k);
        if (m == 1 || m == 3) return k % 3;
        if (m == 2) return (k < 3) ? 0 : 1;
        return 0;
    endfunction

    // Command word: enable plus scan, interval, divide and width bits
    function automatic logic [31:0] cmd_of(input int m);
        case (m)
            1:       return 32'h0000_0007;
            2:       return 32'h0000_000B;
            3:       return 32'h0000_0003;
            4:       return 32'h0000_0011;
            default: return 32'h0000_0001;
        endcase
    endfunction

    // Modes: 0 single channel, 1 timed scan, 2 divided stepping,
    // 3 scan without interval, 4 cascaded count; odd modes soft start
    task automatic run(input int m);
        logic [31:0] r;
        logic [14:0] e[3];
        int n, k, cnt;
        n   = (m == 2) ? 8 : 2 + ($random(seed) & 3);
        cnt = (m == 4) ? 12 : 6;
        wb(1, REG_SEQ_CLEAR, 0, r);
        for (k = 0; k < 3; k++) begin
            e[k] = $random(seed);
            wb(1, REG_SEQ_ENTRY, {k == 2, e[k]}, r);
        end
        wb(1, REG_SMP_INTVL, n, r);
        wb(1, REG_SMP_COUNT, 6, r);
        wb(1, REG_SCN_INTVL, 80, r);
        fc_seen = 0;
        wb(1, REG_CONV_CLR, 0, r);
        repeat (2) @(posedge clk_i);
        chk(fc_seen, "fifo clear missing");
        wb(1, REG_SEQ_LOAD, 0, r);
        seen.delete();
        n_eos = 0;
        cur_mode = m;
        wb(1, REG_CMD1, cmd_of(m), r);
        repeat (20) @(posedge clk_i);
        chk(seen.size() == 0, "conversion before trigger");
        if (m % 2) wb(1, REG_ACQ_START, 0, r);
        else begin
            trig <= 1;
            @(posedge clk_i);
            trig <= 0;
        end
        repeat (4) @(posedge clk_i);
        for (k = 0; k < 3000 && act === 1'b1; k++) @(posedge clk_i);
        repeat (40) @(posedge clk_i);
        chk(seen.size() == cnt, "sample count");
        chk(t2 - t1 == 2 * n, "sample interval");
        for (k = 0; k < cnt && k < seen.size(); k++)
            chk(seen[k] === e[exp_idx(m, k)], "entry order");
        chk(n_eos == ((m == 1 || m == 3) ? 2 : 0), "end flag");
        if (m == 1) chk(t4 - t1 >= 160 && t4 - t1 <= 164 + 2 * n,
                        "pass not held");
        else chk(t4 - t1 == 6 * n, "unexpected pause");
        wb(0, REG_SMP_LEFT, 0, r);
        chk(r[16:0] === ((m == 4) ? 17'h00006 : 17'h00000),
            "samples left");
        wb(0, REG_STATUS, 0, r);
        chk(r[1:0] === 2'b00, "still active");
        wb(0, REG_SCN_INTVL, 0, r);
        chk(r[15:0] === 16'h0050, "scan interval readback");
        $display("test %0d done", m);
    endtask

    task conclude;
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    // Watchdog well past the expected run length
    initial begin
        #(40 * 30000);
        bad_count++;
        conclude;
    end

    // Main sequence
    initial begin
        logic [31:0] r;
        repeat (16) @(posedge clk_i);
        rst_i <= 0;
        wb(0, REG_CMD1, 0, r);
        chk(r[4:0] === CMD1_RST, "cmd1 reset");
        wb(0, REG_SMP_INTVL, 0, r);
        chk(r[15:0] === INTVL_RST, "interval reset");
        wb(0, REG_SMP_COUNT, 0, r);
        chk(r[15:0] === COUNT_RST, "count reset");
        wb(0, 8'hFC, 0, r);
        chk(r === 32'h0, "unmapped read");
        run(0);
        run(1);
        run(2);
        run(3);
        run(4);
        conclude;
    end
endmodule
`default_nettype wire
